// file: bench/ebwrs_ext_mem.sv
`timescale 1ns/1ps
// behavioural external memory, one byte per area
module ebwrs_ext_mem (
  // strobes and selects from the controller
  input  wire logic [7:0] cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  // data from and to the controller
  input  wire logic [7:0] dq_i,
  input  wire logic       dq_oe_n_i,
  output logic      [7:0] dq_o
);
  // one stored byte for each area
  logic [7:0] mem [8];
  // selected area, 8 when none
  int         sel;

  // lowest active select wins
  always_comb begin
    sel = 8;
    for (int i = 7; i >= 0; i--) begin
      if (cs_n_i[i] == 1'b0) begin
        sel = i;
      end
    end
  end

  // store while write strobe and data drive are both active
  always @(wr_n_i or dq_i or dq_oe_n_i or sel) begin
    if (wr_n_i === 1'b0 && dq_oe_n_i === 1'b0 && sel < 8) begin
      mem[sel] = dq_i;
    end
  end

  // no pull on the data lines: undriven shows the inverse of last
  initial dq_o = 8'h00;
  always @(rd_n_i or sel) begin
    if (rd_n_i === 1'b0 && sel < 8) begin
      dq_o = mem[sel];
    end else begin
      dq_o = ~dq_o;
    end
  end
endmodule

// file: bench/ext_bus_wait_read_strobe_timing_test.sv
`timescale 1ns/1ps
`include "ebwrs_regs.svh"
module ext_bus_wait_read_strobe_timing_test;
  import ebwrs_pkg::*;
  // clock, reset and apb
  logic        clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o;
  // access request side
  logic        start_i, write_i, basic_i, busy_o, done_o;
  ebwrs_area_t area_i;
  ebwrs_wait_t other_wait_i;
  logic [7:0]  wdata_i, rdata_o;
  // external pins
  logic [7:0]  cs_n_o, dq_i, dq_o;
  logic        rd_n_o, wr_n_o, dq_oe_n_o;
  // bookkeeping
  int          errors, n_compared, base_cyc;

  ebwrs_top u_ebwrs_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .start_i(start_i),
    .area_i(area_i), .write_i(write_i), .basic_i(basic_i),
    .wdata_i(wdata_i), .other_wait_i(other_wait_i), .busy_o(busy_o),
    .done_o(done_o), .rdata_o(rdata_o), .cs_n_o(cs_n_o),
    .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o));

  ebwrs_ext_mem u_ebwrs_ext_mem (.cs_n_i(cs_n_o), .rd_n_i(rd_n_o),
    .wr_n_i(wr_n_o), .dq_i(dq_o), .dq_oe_n_i(dq_oe_n_o), .dq_o(dq_i));

  // 20 mhz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // verdict and end of run
  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a wait ran out of its bound
  task automatic hang();
    errors++;
    report_and_stop();
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int k;
    k = 0;
    rd = 32'h0;
    err = 1'b0;
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      k++;
      if (k > 50) hang();
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // register write, response ignored
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  // one bus access; cycles to done and strobe-low cycles counted
  task automatic access(input int a, input logic wr, input logic bas,
                        input logic [7:0] d, output int cyc,
                        output int rlow, output logic [7:0] rd);
    cyc = 1;
    rlow = 0;
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    area_i  <= 3'(a);
    write_i <= wr;
    basic_i <= bas;
    wdata_i <= d;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    @(negedge clk_sys_i);
    chk({31'h0, busy_o}, 32'h1);
    while (done_o !== 1'b1) begin
      if (rd_n_o === 1'b0) rlow++;
      cyc++;
      if (cyc > 200) hang();
      @(negedge clk_sys_i);
    end
    chk({31'h0, busy_o}, 32'h0);
    rd = rdata_o;
  endtask

  // reset values of all registers
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    apb(1'b0, `EBWRS_OFS_WAIT, 32'h0, r, e);
    chk(r, 32'h77);
    apb(1'b0, `EBWRS_OFS_STROBE, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, `EBWRS_OFS_ACCESS, 32'h0, r, e);
    chk(r, 32'h3);
    apb(1'b0, `EBWRS_OFS_STATUS, 32'h0, r, e);
    chk(r, 32'h0);
  endtask

  // reset in mid-run restores every register
  task automatic t_rerun();
    wreg(`EBWRS_OFS_WAIT, 8'h00);
    wreg(`EBWRS_OFS_STROBE, 8'hff);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
  endtask

  // reserved bits, strobe bits, unmapped place
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    wreg(`EBWRS_OFS_WAIT, 8'hff);
    apb(1'b0, `EBWRS_OFS_WAIT, 32'h0, r, e);
    chk(r, 32'h77);
    wreg(`EBWRS_OFS_WAIT, 8'h88);
    apb(1'b0, `EBWRS_OFS_WAIT, 32'h0, r, e);
    chk(r, 32'h0);
    wreg(`EBWRS_OFS_STROBE, 8'ha5);
    apb(1'b0, `EBWRS_OFS_STROBE, 32'h0, r, e);
    chk(r, 32'ha5);
    wreg(12'h010, 8'hff);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask

  // every wait code on areas 0 and 1, then enables cleared
  task automatic t_waits();
    int         c;
    int         rl;
    logic [7:0] d;
    wreg(`EBWRS_OFS_ACCESS, 8'h03);
    for (int a = 0; a < 2; a++) begin
      for (int w = 0; w < 8; w++) begin
        wreg(`EBWRS_OFS_WAIT, 8'(w << (4 * a)));
        access(a, 1'b1, 1'b1, 8'h00, c, rl, d);
        if (w == 0) base_cyc = c;
        chk(32'(c - base_cyc), 32'(2 * w));
      end
    end
    wreg(`EBWRS_OFS_ACCESS, 8'h00);
    wreg(`EBWRS_OFS_WAIT, 8'h77);
    for (int a = 0; a < 2; a++) begin
      access(a, 1'b1, 1'b1, 8'h00, c, rl, d);
      chk(32'(c), 32'(base_cyc));
    end
    wreg(`EBWRS_OFS_ACCESS, 8'h03);
    wreg(`EBWRS_OFS_WAIT, 8'h00);
  endtask

  // per-area strobe negation, others set the opposite way
  task automatic t_strobe();
    int         cn;
    int         ce;
    int         rl;
    logic [7:0] d;
    for (int n = 0; n < 8; n++) begin
      access(n, 1'b1, 1'b1, 8'h5a ^ 8'(n), cn, rl, d);
      wreg(`EBWRS_OFS_STROBE, ~(8'h01 << n));
      access(n, 1'b0, 1'b1, 8'h00, cn, rl, d);
      chk(32'(rl), 32'h3);
      chk({24'h0, d}, {24'h0, 8'h5a ^ 8'(n)});
      wreg(`EBWRS_OFS_STROBE, 8'h01 << n);
      access(n, 1'b0, 1'b1, 8'h00, ce, rl, d);
      chk(32'(rl), 32'h2);
      chk({24'h0, d}, {24'h0, 8'h5a ^ 8'(n)});
      chk(32'(cn - ce), 32'h1);
    end
  endtask

  // early negation only for basic bus reads
  task automatic t_nonbasic();
    int         c;
    int         rl;
    logic [7:0] d;
    wreg(`EBWRS_OFS_STROBE, 8'hff);
    access(3, 1'b0, 1'b0, 8'h00, c, rl, d);
    chk(32'(rl), 32'h3);
    chk({24'h0, d}, 32'h59);
    access(3, 1'b1, 1'b1, 8'h3c, c, rl, d);
    chk(32'(rl), 32'h0);
    access(3, 1'b0, 1'b1, 8'h00, c, rl, d);
    chk({24'h0, d}, 32'h3c);
  endtask

  // main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    base_cyc = 0;
    rst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    start_i = 1'b0;
    area_i = 3'h0;
    write_i = 1'b0;
    basic_i = 1'b0;
    wdata_i = 8'h00;
    other_wait_i = 3'h0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_waits();
    t_strobe();
    t_nonbasic();
    t_rerun();
    report_and_stop();
  end
endmodule

// file: hw/ebwrs_pin_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for the data pins
module ebwrs_pin_sync (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // pin side and synchronised side
  input  wire logic [7:0] pin_i,
  output logic      [7:0] sync_o
);
  logic [7:0] meta_reg;   // first stage, read only by second
  logic [7:0] sync_reg;   // second stage

  // plain two-stage chain
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// file: hw/ebwrs_pkg.sv
package ebwrs_pkg;

  // area number of an external access
  typedef logic [2:0] ebwrs_area_t;

  // program wait state count
  typedef logic [2:0] ebwrs_wait_t;

  // bus cycle states, gray coded along idle-t1-tw-t2-cap
  typedef enum logic [2:0] {
    EBWRS_IDLE = 3'h0,
    EBWRS_T1   = 3'h1,
    EBWRS_TW   = 3'h3,
    EBWRS_T2   = 3'h2,
    EBWRS_CAP  = 3'h6
  } ebwrs_state_t;

endpackage

// file: hw/ebwrs_regs.svh
`ifndef EBWRS_REGS_SVH
`define EBWRS_REGS_SVH

// register byte offsets on the apb bus
`define EBWRS_OFS_WAIT      12'h000
`define EBWRS_OFS_STROBE    12'h004
`define EBWRS_OFS_ACCESS    12'h008
`define EBWRS_OFS_STATUS    12'h00c

// reset values
`define EBWRS_RST_WAIT      8'h77
`define EBWRS_RST_STROBE    8'h00
`define EBWRS_RST_ACCESS    2'h3

// writable bits of the wait register, bits 7 and 3 stay zero
`define EBWRS_WAIT_MASK     8'h77

// field positions
`define EBWRS_A0_WAIT_LSB   0
`define EBWRS_A1_WAIT_LSB   4
`define EBWRS_EN0_BIT       0
`define EBWRS_EN1_BIT       1

// capture delay through the data pin synchroniser, in half-states
`define EBWRS_SYNC_DEPTH    2

`endif

// file: hw/ebwrs_top.sv
// Function
// - area1 waits from field when enabled
// - area0 waits from field when enabled
// - both wait fields reset to seven
// - wait register bits 7,3 read zero
// - early negation only basic bus reads
// - eight strobe bits, one per area
// - bit clear: strobe negates at cycle end
// - bit set: negates half-state earlier
// - early negation moves data capture earlier
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "ebwrs_regs.svh"
module ebwrs_top (
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  // apb slave
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [11:0]             paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // access request from the bus master side
  input  wire logic                    start_i,
  input  wire ebwrs_pkg::ebwrs_area_t  area_i,
  input  wire logic                    write_i,
  input  wire logic                    basic_i,
  input  wire logic [7:0]              wdata_i,
  input  wire ebwrs_pkg::ebwrs_wait_t  other_wait_i,
  output logic                         busy_o,
  output logic                         done_o,
  output logic      [7:0]              rdata_o,
  // external bus pins
  output logic      [7:0]              cs_n_o,
  output logic                         rd_n_o,
  output logic                         wr_n_o,
  input  wire logic [7:0]              dq_i,
  output logic      [7:0]              dq_o,
  output logic                         dq_oe_n_o
);
  import ebwrs_pkg::*;

  // wait field picked for an area, enables gate areas 0 and 1
  function automatic ebwrs_wait_t wait_pick(
    input ebwrs_area_t a,
    input logic [7:0]  w,
    input logic [1:0]  en,
    input ebwrs_wait_t other
  );
    ebwrs_wait_t r;
    r = other;
    if (a == 3'h0) begin
      r = en[`EBWRS_EN0_BIT] ? w[`EBWRS_A0_WAIT_LSB +: 3] : 3'h0;
    end else if (a == 3'h1) begin
      r = en[`EBWRS_EN1_BIT] ? w[`EBWRS_A1_WAIT_LSB +: 3] : 3'h0;
    end
    return r;
  endfunction

  // registers
  logic [7:0]   wait_ctrl_low_areas_reg;   // area 0/1 wait fields
  logic [7:0]   read_strobe_timing_reg;    // early negation per area
  logic [1:0]   access_state_ctrl_reg;     // wait enables, areas 0/1
  logic [31:0]  prdata_reg;                // read data for the bus
  logic         pready_reg;                // access phase answer
  logic         pslverr_reg;               // unmapped address flag

  // bus cycle engine
  ebwrs_state_t state_reg;                 // current bus state
  ebwrs_state_t state_next;                // next bus state
  logic         phase_reg;                 // second half-state flag
  ebwrs_area_t  area_reg;                  // latched area
  logic         write_reg;                 // latched direction
  logic         early_reg;                 // early negation in force
  logic [7:0]   wdata_reg;                 // latched write data
  logic [1:0]   cap_dly_reg;               // capture point delay line
  logic [7:0]   rdata_reg;                 // captured read data
  logic         done_reg;                  // completion pulse
  logic         busy_reg;                  // access in progress

  // pin flops
  logic [7:0]   cs_n_reg;                  // chip selects
  logic         rd_n_reg;                  // read strobe
  logic         wr_n_reg;                  // write strobe
  logic [7:0]   dq_reg;                    // data out
  logic         dq_oe_n_reg;               // data drive, low drives

  // decode wires
  wire          apb_setup  = psel_i && !penable_i;
  wire          apb_wr     = psel_i && penable_i && pready_reg && pwrite_i;
  wire          hit_wait   = paddr_i == `EBWRS_OFS_WAIT;
  wire          hit_strobe = paddr_i == `EBWRS_OFS_STROBE;
  wire          hit_access = paddr_i == `EBWRS_OFS_ACCESS;
  wire          hit_status = paddr_i == `EBWRS_OFS_STATUS;
  wire          hit_any    = hit_wait || hit_strobe || hit_access ||
                             hit_status;
  wire          accept     = start_i && (state_reg == EBWRS_IDLE);
  wire          half_end   = phase_reg;
  wire          is_read    = !write_reg;
  wire [7:0]    dq_sync;
  ebwrs_wait_t  wait_count;
  ebwrs_wait_t  wait_load;

  // effective waits for the new access
  assign wait_load = wait_pick(area_i, wait_ctrl_low_areas_reg,
                               access_state_ctrl_reg, other_wait_i);

  // early negation only for basic interface reads
  wire          early_new  = read_strobe_timing_reg[area_i] &&
                             basic_i && !write_i;

  // strobe point: the half-state at whose end rd negates
  wire          strobe_pt  = (state_reg == EBWRS_T2) && is_read &&
                             (early_reg ? !phase_reg : phase_reg);

  // read strobe low window
  wire          rd_low     = is_read && (state_reg != EBWRS_IDLE) &&
                             (state_reg != EBWRS_CAP) &&
                             !((state_reg == EBWRS_T1) && !phase_reg) &&
                             !((state_reg == EBWRS_T2) && phase_reg &&
                               early_reg);

  // write strobe low window, second half of t1 through first of t2
  wire          wr_low     = write_reg &&
                             (((state_reg == EBWRS_T1) && phase_reg) ||
                              (state_reg == EBWRS_TW) ||
                              ((state_reg == EBWRS_T2) && !phase_reg));

  // data drive window covers the whole write cycle
  wire          dq_drive   = write_reg && (state_reg != EBWRS_IDLE) &&
                             (state_reg != EBWRS_CAP);

  // status word for software
  wire [31:0]   status_word = {24'h0, 3'h0, busy_reg, area_reg,
                               state_reg == EBWRS_TW};

  // read mux
  wire [31:0]   rd_mux = hit_wait   ? {24'h0, wait_ctrl_low_areas_reg} :
                         hit_strobe ? {24'h0, read_strobe_timing_reg} :
                         hit_access ? {30'h0, access_state_ctrl_reg} :
                         hit_status ? status_word : 32'h0;

  // wait state counter
  ebwrs_wait_cnt u_wait_cnt (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .load_i     (accept),
    .load_val_i (wait_load),
    .dec_i      ((state_reg == EBWRS_TW) && half_end),
    .count_o    (wait_count)
  );

  // data pin synchroniser
  ebwrs_pin_sync u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (dq_i),
    .sync_o    (dq_sync)
  );

  // apb answer: data and error ready in setup, pready in access
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_setup;
      if (apb_setup) begin
        prdata_reg  <= pwrite_i ? 32'h0 : rd_mux;
        pslverr_reg <= !hit_any;
      end
    end
  end

  // software registers, written at the access edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wait_ctrl_low_areas_reg <= `EBWRS_RST_WAIT;
      read_strobe_timing_reg  <= `EBWRS_RST_STROBE;
      access_state_ctrl_reg   <= `EBWRS_RST_ACCESS;
    end else if (apb_wr) begin
      if (hit_wait) begin
        wait_ctrl_low_areas_reg <= pwdata_i[7:0] & `EBWRS_WAIT_MASK;
      end
      if (hit_strobe) begin
        read_strobe_timing_reg <= pwdata_i[7:0];
      end
      if (hit_access) begin
        access_state_ctrl_reg <= pwdata_i[1:0];
      end
    end
  end

  // next state: t1 on accept; tw, t2, cap on half-state ends; idle after write t2 or capture
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EBWRS_IDLE: begin
        if (accept) begin
          state_next = EBWRS_T1;
        end
      end
      EBWRS_T1: begin
        if (half_end) begin
          state_next = (wait_count == 3'h0) ? EBWRS_T2 : EBWRS_TW;
        end
      end
      EBWRS_TW: begin
        if (half_end && wait_count == 3'h1) begin
          state_next = EBWRS_T2;
        end
      end
      EBWRS_T2: begin
        if (half_end) begin
          state_next = is_read ? EBWRS_CAP : EBWRS_IDLE;
        end
      end
      EBWRS_CAP: begin
        if (cap_dly_reg[1]) begin
          state_next = EBWRS_IDLE;
        end
      end
      default: begin
        state_next = EBWRS_IDLE;
      end
    endcase
  end

  // state and half-state phase
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= EBWRS_IDLE;
      phase_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= (state_reg == EBWRS_IDLE || state_reg == EBWRS_CAP) ?
                   1'b0 : !phase_reg;
    end
  end

  // access attributes latched on acceptance
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      area_reg  <= 3'h0;
      write_reg <= 1'b0;
      early_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else if (accept) begin
      area_reg  <= area_i;
      write_reg <= write_i;
      early_reg <= early_new;
      wdata_reg <= wdata_i;
    end
  end

  // capture: synchronised data lags the pins by two cycles
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cap_dly_reg <= 2'h0;
      rdata_reg   <= 8'h00;
    end else begin
      cap_dly_reg <= {cap_dly_reg[0], strobe_pt};
      if (cap_dly_reg[1]) begin
        rdata_reg <= dq_sync;
      end
    end
  end

  // handshake flags toward the requester
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg != EBWRS_IDLE) && (state_next == EBWRS_IDLE);
      busy_reg <= state_next != EBWRS_IDLE;
    end
  end

  // pin flops, one cycle behind the engine
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cs_n_reg    <= 8'hff;
      rd_n_reg    <= 1'b1;
      wr_n_reg    <= 1'b1;
      dq_reg      <= 8'h00;
      dq_oe_n_reg <= 1'b1;
    end else begin
      cs_n_reg    <= (state_reg == EBWRS_IDLE || state_reg == EBWRS_CAP) ?
                     8'hff : ~(8'h01 << area_reg);
      rd_n_reg    <= !rd_low;
      wr_n_reg    <= !wr_low;
      dq_reg      <= wdata_reg;
      dq_oe_n_reg <= !dq_drive;
    end
  end

  // outputs straight from flops
  assign prdata_o  = prdata_reg;
  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign busy_o    = busy_reg;
  assign done_o    = done_reg;
  assign rdata_o   = rdata_reg;
  assign cs_n_o    = cs_n_reg;
  assign rd_n_o    = rd_n_reg;
  assign wr_n_o    = wr_n_reg;
  assign dq_o      = dq_reg;
  assign dq_oe_n_o = dq_oe_n_reg;

  // area 1 enabled: counter holds its field after acceptance
  AST_AREA1_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    accept && area_i == 3'h1 && access_state_ctrl_reg[1]
    |=> wait_count == $past(wait_ctrl_low_areas_reg[6:4]))
    else $error("area 1 wait count wrong");

  // area 0 enabled: counter holds its field after acceptance
  AST_AREA0_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    accept && area_i == 3'h0 && access_state_ctrl_reg[0]
    |=> wait_count == $past(wait_ctrl_low_areas_reg[2:0]))
    else $error("area 0 wait count wrong");

  // first cycle after reset shows seven waits for both areas
  AST_WAIT_RESET: assert property (@(posedge clk_sys_i)
    !$past(rst_n_i) && rst_n_i |-> wait_ctrl_low_areas_reg == 8'h77)
    else $error("wait fields not seven after reset");

  // reserved wait bits read back as zero on the bus
  AST_WAIT_RSVD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    apb_setup && hit_wait && !pwrite_i
    |=> prdata_o[7] == 1'b0 && prdata_o[3] == 1'b0)
    else $error("reserved wait bit read as one");

  // writes and non-basic reads never negate early
  AST_EARLY_BASIC: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    accept && (write_i || !basic_i) |=> !early_reg)
    else $error("early negation on non-basic or write");

  // strobe bits clear after reset
  AST_STROBE_RESET: assert property (@(posedge clk_sys_i)
    !$past(rst_n_i) && rst_n_i |-> read_strobe_timing_reg == 8'h00)
    else $error("strobe bits not clear after reset");

  // normal read: strobe low through the last half-state, then high
  AST_NORMAL_NEG: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    state_reg == EBWRS_T2 && phase_reg && is_read && !early_reg
    |=> !rd_n_o ##1 rd_n_o)
    else $error("normal read strobe negation wrong");

  // early read: strobe high during the last half-state
  AST_EARLY_NEG: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_reg == EBWRS_T2 && !phase_reg && is_read && early_reg
    |=> !rd_n_o ##1 rd_n_o)
    else $error("early read strobe negation wrong");

  // capture point two cycles after strobe point
  AST_CAPTURE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    strobe_pt |-> ##2 cap_dly_reg[1] ##1 done_reg)
    else $error("read capture not aligned to strobe");

  // disabled area 0: no wait states at all
  AST_NO_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    accept && area_i == 3'h0 && !access_state_ctrl_reg[0]
    |=> wait_count == 3'h0 ##2 state_reg == EBWRS_T2)
    else $error("waits inserted with enable clear");

endmodule

// file: hw/ebwrs_wait_cnt.sv
`timescale 1ns/1ps
// program wait state down counter
module ebwrs_wait_cnt (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // control
  input  wire logic                 load_i,
  input  wire ebwrs_pkg::ebwrs_wait_t load_val_i,
  input  wire logic                 dec_i,
  // state
  output ebwrs_pkg::ebwrs_wait_t    count_o
);
  import ebwrs_pkg::*;

  ebwrs_wait_t cnt_reg;   // remaining wait states

  // load wins over decrement, never wraps below zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 3'h0;
    end else if (load_i) begin
      cnt_reg <= load_val_i;
    end else if (dec_i && cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  assign count_o = cnt_reg;
endmodule
